// File: hw/sbc_mode_pkg.sv
/*
  Shared constants, state codes and helpers for the operating-mode controller.
  Assumes a single 25 MHz core clock; all durations are counted in milliseconds.
*/
package sbc_mode_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_TICK_CYC = CLK_HZ / MS_PER_S;
  localparam int unsigned POR_MS = 1;
  localparam int unsigned RST_MS = 1;
  localparam int unsigned RST_LONG_MS = 8;
  localparam int unsigned INIT_TIMEOUT_MS = 256;
  localparam int unsigned NREQ_TIMEOUT_MS = 256;
  localparam int unsigned WD_PERIOD_MS = 64;
  localparam int unsigned FLASH_PERIOD_S = 32;
  localparam int unsigned FLASH_PERIOD_MS = FLASH_PERIOD_S * MS_PER_S;
  localparam int MS_W = 16;
  localparam int NUM_INIT_REGS = 4;
  localparam int INIT_REG_W = 8;
  localparam logic [INIT_REG_W-1:0] INIT_REG_RST = 8'h00;
  localparam int NUM_WAKE = 4;
  localparam int NUM_INT = 2;
  localparam int INT_FLASH_HALF = 0;
  localparam int INT_LP_WAKE = 1;
  localparam int PULSE_W = 3;

  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_INIT = 3'h1,
    ST_RESET = 3'h2,
    ST_NREQ = 3'h3,
    ST_NORMAL = 3'h4,
    ST_FLASH = 3'h5,
    ST_LP_ON = 3'h6,
    ST_LP_OFF = 3'h7
  } mode_t;

  typedef enum logic [1:0] {
    SEC_NONE = 2'h0,
    SEC_RESET = 2'h1,
    SEC_INIT = 2'h2,
    SEC_FLASH = 2'h3
  } sec_tgt_t;

  function automatic logic [MS_W-1:0] ms_c(input int unsigned v);
    return MS_W'(v);
  endfunction : ms_c
endpackage : sbc_mode_pkg

// File: hw/sbc_int_if.sv
/*
  Carrier between the mode controller and the interrupt output shaper.
  Assumes both ends share core_clk_i.
*/
`timescale 1ns/1ps
interface sbc_int_if;
  logic tick;
  logic evt;
  logic level_mode;
  logic clr;
  logic [sbc_mode_pkg::PULSE_W-1:0] pulse_sel;
  logic int_n;
  modport ctrl (output tick, output evt, output level_mode, output clr, output pulse_sel, input int_n);
  modport shaper (input tick, input evt, input level_mode, input clr, input pulse_sel, output int_n);
endinterface : sbc_int_if

// File: hw/int_shaper.sv
/*
  Active-low interrupt output: held low level or timed low pulse.
  Assumes evt and clr are one-cycle pulses and tick is the millisecond enable.
*/
`timescale 1ns/1ps
module int_shaper (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // control side
  sbc_int_if.shaper bus
);
  localparam int CNT_W = sbc_mode_pkg::PULSE_W + 1;

  logic pend;
  logic [CNT_W-1:0] cnt;

  // held level: a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pend <= 1'b0;
    else if (bus.evt && bus.level_mode)
      pend <= 1'b1;
    else if (bus.clr || !bus.level_mode)
      pend <= 1'b0;
  end

  // pulse of pulse_sel+1 ms
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt <= '0;
    else if (bus.evt && !bus.level_mode)
      cnt <= CNT_W'(bus.pulse_sel) + 1'b1;
    else if (bus.tick && cnt != '0)
      cnt <= cnt - 1'b1;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      bus.int_n <= 1'b1;
    else
      bus.int_n <= bus.level_mode ? !pend : (cnt == '0);
  end

  chk_int_level_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (bus.level_mode && bus.evt) ##1 bus.level_mode |=> !bus.int_n)
    else $error("held interrupt level not asserted");
  chk_int_pulse_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!bus.level_mode && bus.evt) ##1 !bus.level_mode |=> !bus.int_n)
    else $error("interrupt pulse not started");
  chk_int_pulse_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!bus.level_mode && cnt == '0 && !bus.evt) ##1 !bus.level_mode |=> bus.int_n)
    else $error("interrupt pulse outlasts its width");
  cov_int_fall: cover property (@(posedge core_clk_i) disable iff (rst_i) $fell(bus.int_n));
endmodule : int_shaper

// File: hw/sbc_mode_fsm.sv
/*
  Operating-mode controller: power-on reset, init window, reset, normal request,
  normal, flash, debug and the two sleep modes; drives reset and interrupt lines.
  Assumes an spi decoder on core_clk_i delivering commands as one-cycle pulses
  and configuration as levels; pins are asynchronous and synchronised here.
*/
`timescale 1ns/1ps
module sbc_mode_fsm #(
  parameter int unsigned MS_TICK_CYC = sbc_mode_pkg::MS_TICK_CYC,
  parameter int unsigned WD_PERIOD_MS = sbc_mode_pkg::WD_PERIOD_MS,
  parameter int unsigned RST_LONG_MS = sbc_mode_pkg::RST_LONG_MS
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // asynchronous pins
  input wire logic debug_select_pin_i,
  input wire logic vdd_low_i,
  input wire logic [sbc_mode_pkg::NUM_WAKE-1:0] wake_evt_i,
  // spi command pulses
  input wire logic wd_refresh_i,
  input wire logic wd_bad_i,
  input wire logic secure_cmd_i,
  input wire logic secure_ok_i,
  input wire logic [1:0] secure_tgt_i,
  input wire logic flash_exit_i,
  input wire logic lp_req_i,
  input wire logic lp_on_wake_i,
  input wire logic debug_exit_i,
  input wire logic init_wr_i,
  input wire logic [$clog2(sbc_mode_pkg::NUM_INIT_REGS)-1:0] init_sel_i,
  input wire logic [sbc_mode_pkg::INIT_REG_W-1:0] init_wdata_i,
  input wire logic power_loss_clr_i,
  input wire logic wake_src_clr_i,
  input wire logic int_clr_i,
  // spi configuration levels
  input wire logic lp_supply_on_i,
  input wire logic wake_flags_set_i,
  input wire logic rst_long_sel_i,
  input wire logic [7:0] nreq_lp_ms_i,
  input wire logic int_level_mode_i,
  input wire logic [sbc_mode_pkg::PULSE_W-1:0] int_pulse_sel_i,
  input wire logic [sbc_mode_pkg::NUM_INT-1:0] int_en_i,
  input wire logic pass_req_i,
  input wire logic can_supply_req_i,
  // host lines
  output logic rst_n_o,
  output logic int_n_o,
  // status
  output logic [2:0] mode_o,
  output logic power_loss_o,
  output logic debug_active_o,
  output logic lp_refused_o,
  output logic [sbc_mode_pkg::NUM_WAKE-1:0] wake_src_o,
  output logic [sbc_mode_pkg::NUM_INIT_REGS*sbc_mode_pkg::INIT_REG_W-1:0] init_cfg_o,
  // supply and function enables
  output logic pass_en_o,
  output logic periph_en_o,
  output logic can_supply_en_o,
  output logic vdd_en_o
);
  localparam int MS_W = sbc_mode_pkg::MS_W;
  localparam int SYNC_W = sbc_mode_pkg::NUM_WAKE + 2;
  localparam int TICK_W = $clog2(MS_TICK_CYC + 1);
  sbc_mode_pkg::mode_t state, next_state;
  logic [SYNC_W-1:0] sync1, sync2;
  logic dbg_s, vdd_low_s;
  logic [sbc_mode_pkg::NUM_WAKE-1:0] wake_s;
  logic [TICK_W-1:0] div_cnt;
  logic ms_tick;
  logic [MS_W-1:0] ms_cnt, rst_limit, nreq_limit;
  logic rst_long, nreq_from_lp;
  logic wd_early, wd_expired, wd_fail, wd_trip;
  logic sec_ok, lp_ok, dbg_leave, ms_clear;
  logic [sbc_mode_pkg::NUM_INT-1:0] int_evt;
  sbc_int_if ib ();
  // pins pass two flip-flops
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      {sync2, sync1} <= {(2 * SYNC_W){1'b0}};
    else
      {sync2, sync1} <= {sync1, wake_evt_i, vdd_low_i, debug_select_pin_i};
  end
  assign dbg_s = sync2[0];
  assign vdd_low_s = sync2[1];
  assign wake_s = sync2[SYNC_W-1:2];
  // millisecond enable, restarted with the ms counter so a timed state lasts its full count
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_cnt <= '0;
      ms_tick <= 1'b0;
    end
    else if (ms_clear || div_cnt == TICK_W'(MS_TICK_CYC - 1))
    begin
      div_cnt <= '0;
      ms_tick <= !ms_clear;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
      ms_tick <= 1'b0;
    end
  end
  always_comb
  begin
    wd_early = (state == sbc_mode_pkg::ST_NORMAL) && (ms_cnt < sbc_mode_pkg::ms_c(WD_PERIOD_MS / 2));
    if (state == sbc_mode_pkg::ST_FLASH)
      wd_expired = ms_cnt >= sbc_mode_pkg::ms_c(sbc_mode_pkg::FLASH_PERIOD_MS);
    else
      wd_expired = ms_cnt >= sbc_mode_pkg::ms_c(WD_PERIOD_MS);
    wd_fail = wd_bad_i || wd_expired || (wd_refresh_i && wd_early);
    wd_trip = wd_fail && !debug_active_o;
    sec_ok = secure_cmd_i && secure_ok_i;
    lp_ok = lp_req_i && !wake_flags_set_i;
    dbg_leave = debug_active_o && (!dbg_s || debug_exit_i);
    rst_limit = rst_long ? sbc_mode_pkg::ms_c(RST_LONG_MS) : sbc_mode_pkg::ms_c(sbc_mode_pkg::RST_MS);
    nreq_limit = nreq_from_lp ? MS_W'(nreq_lp_ms_i) : sbc_mode_pkg::ms_c(sbc_mode_pkg::NREQ_TIMEOUT_MS);
  end
  always_comb
  begin
    next_state = state;
    case (state)
      sbc_mode_pkg::ST_POR:
        if (ms_cnt >= sbc_mode_pkg::ms_c(sbc_mode_pkg::POR_MS))
          next_state = sbc_mode_pkg::ST_INIT;
      sbc_mode_pkg::ST_INIT:
        if (wd_refresh_i)
          next_state = sbc_mode_pkg::ST_NORMAL;
        else if (!debug_active_o && ms_cnt >= sbc_mode_pkg::ms_c(sbc_mode_pkg::INIT_TIMEOUT_MS))
          next_state = sbc_mode_pkg::ST_POR;
      sbc_mode_pkg::ST_RESET:
        if (ms_cnt >= rst_limit)
          next_state = sbc_mode_pkg::ST_NREQ;
      sbc_mode_pkg::ST_NREQ:
        if (vdd_low_s)
          next_state = sbc_mode_pkg::ST_RESET;
        else if (wd_refresh_i)
          next_state = sbc_mode_pkg::ST_NORMAL;
        else if (!debug_active_o && ms_cnt >= nreq_limit)
          next_state = sbc_mode_pkg::ST_RESET;
      sbc_mode_pkg::ST_NORMAL:
        if (vdd_low_s || wd_trip)
          next_state = sbc_mode_pkg::ST_RESET;
        else if (sec_ok && secure_tgt_i == sbc_mode_pkg::SEC_RESET)
          next_state = sbc_mode_pkg::ST_RESET;
        else if (sec_ok && secure_tgt_i == sbc_mode_pkg::SEC_INIT)
          next_state = sbc_mode_pkg::ST_INIT;
        else if (sec_ok && secure_tgt_i == sbc_mode_pkg::SEC_FLASH)
          next_state = sbc_mode_pkg::ST_FLASH;
        else if (lp_ok)
          next_state = lp_supply_on_i ? sbc_mode_pkg::ST_LP_ON : sbc_mode_pkg::ST_LP_OFF;
      sbc_mode_pkg::ST_FLASH:
        if (vdd_low_s || wd_trip || flash_exit_i)
          next_state = sbc_mode_pkg::ST_RESET;
      sbc_mode_pkg::ST_LP_ON:
        if (vdd_low_s)
          next_state = sbc_mode_pkg::ST_RESET;
        else if (lp_on_wake_i)
          next_state = sbc_mode_pkg::ST_NREQ;
      sbc_mode_pkg::ST_LP_OFF:
        if (|wake_s)
          next_state = sbc_mode_pkg::ST_RESET;
      default:
        next_state = sbc_mode_pkg::ST_POR;
    endcase
  end
  // a refresh or a fault in normal or flash restarts the period
  assign ms_clear = (next_state != state) || dbg_leave ||
    ((state == sbc_mode_pkg::ST_NORMAL || state == sbc_mode_pkg::ST_FLASH) && (wd_refresh_i || wd_fail));
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      state <= sbc_mode_pkg::ST_POR;
    else
      state <= next_state;
  end
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ms_cnt <= '0;
    else if (ms_clear)
      ms_cnt <= '0;
    else if (ms_tick && ms_cnt != '1)
      ms_cnt <= ms_cnt + 1'b1;
  end
  // reset length is chosen on entry
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_long <= 1'b0;
      nreq_from_lp <= 1'b0;
    end
    else
    begin
      if (next_state == sbc_mode_pkg::ST_RESET && state != sbc_mode_pkg::ST_RESET)
        rst_long <= vdd_low_s && rst_long_sel_i && state != sbc_mode_pkg::ST_LP_OFF;
      if (next_state == sbc_mode_pkg::ST_NREQ && state != sbc_mode_pkg::ST_NREQ)
        nreq_from_lp <= state == sbc_mode_pkg::ST_LP_ON;
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      debug_active_o <= 1'b0;
    else if (state == sbc_mode_pkg::ST_POR)
      debug_active_o <= (next_state == sbc_mode_pkg::ST_INIT) && dbg_s;
    else if (dbg_leave)
      debug_active_o <= 1'b0;
  end
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      power_loss_o <= 1'b1;
    else if (state == sbc_mode_pkg::ST_POR)
      power_loss_o <= 1'b1;
    else if (power_loss_clr_i)
      power_loss_o <= 1'b0;
  end
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      init_cfg_o <= {sbc_mode_pkg::NUM_INIT_REGS{sbc_mode_pkg::INIT_REG_RST}};
    else if (state == sbc_mode_pkg::ST_POR)
      init_cfg_o <= {sbc_mode_pkg::NUM_INIT_REGS{sbc_mode_pkg::INIT_REG_RST}};
    else if (state == sbc_mode_pkg::ST_INIT && init_wr_i)
      init_cfg_o[init_sel_i*sbc_mode_pkg::INIT_REG_W +: sbc_mode_pkg::INIT_REG_W] <= init_wdata_i;
  end
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      wake_src_o <= '0;
    else if (state == sbc_mode_pkg::ST_POR)
      wake_src_o <= '0;
    else if (state == sbc_mode_pkg::ST_LP_OFF && |wake_s)
      wake_src_o <= wake_src_o | wake_s;
    else if (wake_src_clr_i)
      wake_src_o <= '0;
  end
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      lp_refused_o <= 1'b0;
    else
      lp_refused_o <= state == sbc_mode_pkg::ST_NORMAL && lp_req_i && wake_flags_set_i;
  end
  // outputs follow the next state so they change with it, except can_supply_en_o, which follows periph_en_o, or debug_active_o in init, one cycle later
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_n_o <= 1'b0;
      mode_o <= sbc_mode_pkg::ST_POR;
      pass_en_o <= 1'b0;
      periph_en_o <= 1'b0;
      can_supply_en_o <= 1'b0;
      vdd_en_o <= 1'b1;
    end
    else
    begin
      rst_n_o <= !(next_state == sbc_mode_pkg::ST_POR || next_state == sbc_mode_pkg::ST_RESET);
      mode_o <= next_state;
      pass_en_o <= pass_req_i &&
        (next_state == sbc_mode_pkg::ST_NORMAL || next_state == sbc_mode_pkg::ST_FLASH);
      periph_en_o <= next_state == sbc_mode_pkg::ST_NORMAL || next_state == sbc_mode_pkg::ST_FLASH ||
        next_state == sbc_mode_pkg::ST_NREQ;
      if (next_state == sbc_mode_pkg::ST_INIT)
        can_supply_en_o <= debug_active_o;
      else
        can_supply_en_o <= periph_en_o && (can_supply_req_i || debug_active_o);
      vdd_en_o <= next_state != sbc_mode_pkg::ST_LP_OFF;
    end
  end
  // interrupt sources: flash half period, wake from sleep with supply on
  always_comb
  begin
    int_evt = '0;
    int_evt[sbc_mode_pkg::INT_FLASH_HALF] = state == sbc_mode_pkg::ST_FLASH && ms_tick && !ms_clear &&
      ms_cnt == sbc_mode_pkg::ms_c(sbc_mode_pkg::FLASH_PERIOD_MS / 2 - 1);
    int_evt[sbc_mode_pkg::INT_LP_WAKE] = state == sbc_mode_pkg::ST_LP_ON && lp_on_wake_i;
  end
  assign ib.tick = ms_tick;
  assign ib.evt = |(int_evt & int_en_i);
  assign ib.level_mode = int_level_mode_i;
  assign ib.clr = int_clr_i;
  assign ib.pulse_sel = int_pulse_sel_i;
  assign int_n_o = ib.int_n;
  int_shaper int_shaper_inst (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .bus(ib.shaper)
  );
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  chk_reset_states_low: assert property (
    (state == sbc_mode_pkg::ST_POR || state == sbc_mode_pkg::ST_RESET) |-> !rst_n_o)
    else $error("reset line high in a reset state");
  chk_init_timeout_por: assert property (
    (state == sbc_mode_pkg::ST_INIT && !debug_active_o && !wd_refresh_i &&
     ms_cnt >= sbc_mode_pkg::ms_c(sbc_mode_pkg::INIT_TIMEOUT_MS)) |=> state == sbc_mode_pkg::ST_POR ##1 !rst_n_o)
    else $error("init timeout did not return to power-on reset");
  chk_debug_keeps_init: assert property (
    (state == sbc_mode_pkg::ST_INIT && debug_active_o && !wd_refresh_i) |=> state == sbc_mode_pkg::ST_INIT)
    else $error("init left without refresh in debug");
  chk_init_regs_locked: assert property (
    (state != sbc_mode_pkg::ST_INIT && state != sbc_mode_pkg::ST_POR) |=> $stable(init_cfg_o))
    else $error("init register changed outside init");
  chk_init_to_normal: assert property (
    (state == sbc_mode_pkg::ST_INIT && wd_refresh_i) |=> state == sbc_mode_pkg::ST_NORMAL && rst_n_o)
    else $error("refresh in init did not reach normal");
  chk_pass_only_active: assert property (
    !(state == sbc_mode_pkg::ST_NORMAL || state == sbc_mode_pkg::ST_FLASH) |-> !pass_en_o)
    else $error("pass transistor enabled in wrong state");
  chk_wd_fault_reset: assert property (
    (state == sbc_mode_pkg::ST_NORMAL && wd_bad_i && !debug_active_o) |=> state == sbc_mode_pkg::ST_RESET && !rst_n_o)
    else $error("bad refresh did not reset");
  chk_reset_short: assert property (
    (state == sbc_mode_pkg::ST_RESET && !rst_long) |-> ms_cnt <= sbc_mode_pkg::ms_c(sbc_mode_pkg::RST_MS))
    else $error("short reset ran too long");
  chk_lp_refused: assert property (
    (state == sbc_mode_pkg::ST_NORMAL && lp_req_i && wake_flags_set_i) |=>
    lp_refused_o && state != sbc_mode_pkg::ST_LP_ON && state != sbc_mode_pkg::ST_LP_OFF)
    else $error("sleep entered with wake flags set");
  chk_wake_via_reset: assert property (
    (state == sbc_mode_pkg::ST_LP_OFF && |wake_s) |=> state == sbc_mode_pkg::ST_RESET && vdd_en_o)
    else $error("wake did not pass through reset");
  chk_nreq_refresh: assert property (
    (state == sbc_mode_pkg::ST_NREQ && wd_refresh_i && !vdd_low_s) |=> state == sbc_mode_pkg::ST_NORMAL)
    else $error("refresh in normal request ignored");
  chk_secure_reset: assert property (
    (state == sbc_mode_pkg::ST_NORMAL && sec_ok && secure_tgt_i == sbc_mode_pkg::SEC_RESET) |=>
    state == sbc_mode_pkg::ST_RESET)
    else $error("secured reset request ignored");
  chk_init_periph_off: assert property (
    state == sbc_mode_pkg::ST_INIT |-> !periph_en_o)
    else $error("peripherals enabled in init");
  cov_init_to_normal: cover property (state == sbc_mode_pkg::ST_INIT ##1 state == sbc_mode_pkg::ST_NORMAL);
  cov_flash_entry: cover property (state == sbc_mode_pkg::ST_NORMAL ##1 state == sbc_mode_pkg::ST_FLASH);
  cov_lp_off_wake: cover property (state == sbc_mode_pkg::ST_LP_OFF ##1 state == sbc_mode_pkg::ST_RESET);
  cov_debug_on: cover property ($rose(debug_active_o));
endmodule : sbc_mode_fsm

// File: verification/sbc_host_model.sv
/*
  Host side of the reset and interrupt lines: measures low pulse lengths.
  Assumes it shares the core clock with the mode controller.
*/
`timescale 1ns/1ps
module sbc_host_model (
  // clock
  input wire logic core_clk_i,
  // lines from the controller
  input wire logic rst_n_i,
  input wire logic int_n_i,
  // latest low pulse lengths in cycles
  output int rst_len_o,
  output int int_len_o
);
  int rcnt = 0;
  int icnt = 0;
  always @(posedge core_clk_i)
  begin
    rcnt <= rst_n_i ? 0 : rcnt + 1;
    if (rst_n_i && rcnt != 0)
      rst_len_o <= rcnt;
    icnt <= int_n_i ? 0 : icnt + 1;
    if (int_n_i && icnt != 0)
      int_len_o <= icnt;
  end
endmodule : sbc_host_model

// File: verification/sbc_mode_fsm_bench.sv
/*
  Self-checking bench for the mode controller, run with a 4-cycle ms tick.
  Assumes the host model is compiled first.
*/
`timescale 1ns/1ps
module sbc_mode_fsm_bench;
  logic core_clk_i = 0;
  logic rst_i = 1;
  logic debug_select_pin_i = 0, vdd_low_i = 0, wd_refresh_i = 0, wd_bad_i = 0, secure_cmd_i = 0;
  logic secure_ok_i = 1, flash_exit_i = 0, lp_req_i = 0, lp_on_wake_i = 0, debug_exit_i = 0;
  logic init_wr_i = 0, power_loss_clr_i = 0, wake_src_clr_i = 0, int_clr_i = 0, lp_supply_on_i = 0;
  logic wake_flags_set_i = 0, rst_long_sel_i = 0, int_level_mode_i = 1, pass_req_i = 1, can_supply_req_i = 0;
  logic [1:0] secure_tgt_i = 2'h1, init_sel_i = 2'h2, int_en_i = 2'h3;
  logic [3:0] wake_evt_i = 4'h0, wake_src_o;
  logic [7:0] init_wdata_i = 8'h5A, nreq_lp_ms_i = 8'h05;
  logic [2:0] int_pulse_sel_i = 3'h0, mode_o;
  logic [31:0] init_cfg_o;
  logic rst_n_o, int_n_o, power_loss_o, debug_active_o, lp_refused_o, pass_en_o, periph_en_o;
  logic can_supply_en_o, vdd_en_o;
  int miscompares = 0, n_compared = 0, rst_len, int_len;

  sbc_mode_fsm #(.MS_TICK_CYC(4), .WD_PERIOD_MS(8)) sbc_mode_fsm_inst (.*);
  sbc_host_model sbc_host_model_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_o), .int_n_i(int_n_o),
    .rst_len_o(rst_len), .int_len_o(int_len));

  always #20 core_clk_i = ~core_clk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : step

  task automatic pulse(ref logic s);
    step(1);
    s = 1;
    step(1);
    s = 0;
  endtask : pulse

  task automatic wm(input logic [2:0] m, input int lim);
    for (int i = 0; i < lim && mode_o !== m; i++)
      step(1);
    chk(mode_o, m);
  endtask : wm

  task automatic rlen(input int lo, input int hi);
    step(2);
    chk(rst_len >= lo && rst_len <= hi, 1'h1);
  endtask : rlen

  task automatic boot(input logic dbg);
    rst_i = 1;
    debug_select_pin_i = dbg;
    step(20);
    chk(rst_n_o, 1'h0);
    chk(power_loss_o, 1'h1);
    rst_i = 0;
    step(3);
    chk(mode_o, 3'h0);
    wm(3'h1, 12);
  endtask : boot

  task automatic t_init;
    boot(1'h0);
    chk(periph_en_o, 1'h0);
    chk(can_supply_en_o, 1'h0);
    chk(pass_en_o, 1'h0);
    pulse(power_loss_clr_i);
    chk(power_loss_o, 1'h0);
    pulse(init_wr_i);
    step(1);
    chk(init_cfg_o, 32'h005A0000);
    pulse(wd_refresh_i);
    chk(mode_o, 3'h4);
    chk(pass_en_o, 1'h1);
    init_wdata_i = 8'hC3;
    pulse(init_wr_i);
    step(1);
    chk(init_cfg_o, 32'h005A0000);
    $display("t_init done");
  endtask : t_init

  task automatic t_normal;
    logic r;
    wake_flags_set_i = 1;
    pulse(lp_req_i);
    r = lp_refused_o;
    step(1);
    chk(r | lp_refused_o, 1'h1);
    chk(mode_o, 3'h4);
    wake_flags_set_i = 0;
    secure_ok_i = 0;
    pulse(secure_cmd_i);
    chk(mode_o, 3'h4);
    secure_ok_i = 1;
    pulse(secure_cmd_i);
    chk(mode_o, 3'h2);
    wm(3'h3, 12);
    rlen(4, 8);
    pulse(wd_refresh_i);
    chk(mode_o, 3'h4);
    $display("t_normal done");
  endtask : t_normal

  task automatic t_supply;
    rst_long_sel_i = 1;
    vdd_low_i = 1;
    wm(3'h2, 6);
    vdd_low_i = 0;
    wm(3'h3, 50);
    rlen(32, 40);
    pulse(wd_refresh_i);
    $display("t_supply done");
  endtask : t_supply

  task automatic t_wdog;
    pulse(wd_bad_i);
    chk(mode_o, 3'h2);
    wm(3'h3, 12);
    rlen(4, 8);
    step(1000);
    chk(mode_o, 3'h3);
    wm(3'h2, 40);
    wm(3'h3, 12);
    pulse(wd_refresh_i);
    step(28);
    chk(mode_o, 3'h4);
    wm(3'h2, 12);
    wm(3'h3, 12);
    pulse(wd_refresh_i);
    step(20);
    pulse(wd_refresh_i);
    chk(mode_o, 3'h4);
    pulse(wd_refresh_i);
    chk(mode_o, 3'h2);
    wm(3'h3, 12);
    pulse(wd_refresh_i);
    $display("t_wdog done");
  endtask : t_wdog

  task automatic t_flash;
    secure_tgt_i = 2'h3;
    pulse(secure_cmd_i);
    chk(mode_o, 3'h5);
    chk(pass_en_o, 1'h1);
    step(40);
    chk(mode_o, 3'h5);
    pulse(flash_exit_i);
    chk(mode_o, 3'h2);
    wm(3'h3, 12);
    pulse(wd_refresh_i);
    secure_tgt_i = 2'h2;
    pulse(secure_cmd_i);
    chk(mode_o, 3'h1);
    pulse(wd_refresh_i);
    $display("t_flash done");
  endtask : t_flash

  task automatic t_sleep_off;
    lp_supply_on_i = 0;
    pulse(lp_req_i);
    chk(mode_o, 3'h7);
    chk(pass_en_o, 1'h0);
    chk(vdd_en_o, 1'h0);
    wake_evt_i = 4'h4;
    wm(3'h2, 6);
    chk(vdd_en_o, 1'h1);
    wake_evt_i = 4'h0;
    wm(3'h3, 12);
    chk(wake_src_o, 4'h4);
    pulse(wd_refresh_i);
    $display("t_sleep_off done");
  endtask : t_sleep_off

  task automatic t_sleep_on(input logic lvl);
    int_level_mode_i = lvl;
    lp_supply_on_i = 1;
    pulse(lp_req_i);
    chk(mode_o, 3'h6);
    pulse(lp_on_wake_i);
    chk(mode_o, 3'h3);
    step(13);
    chk(int_n_o, !lvl);
    chk(mode_o, 3'h3);
    if (lvl)
    begin
      pulse(int_clr_i);
      step(1);
      chk(int_n_o, 1'h1);
    end
    else
      chk(int_len >= 4 && int_len <= 8, 1'h1);
    wm(3'h2, 16);
    wm(3'h3, 12);
    pulse(wd_refresh_i);
    $display("t_sleep_on done");
  endtask : t_sleep_on

  task automatic t_debug;
    boot(1'h1);
    chk(debug_active_o, 1'h1);
    // the bus supply follows the debug flag one cycle later
    step(1);
    chk(can_supply_en_o, 1'h1);
    step(1100);
    chk(mode_o, 3'h1);
    pulse(debug_exit_i);
    step(1);
    chk(debug_active_o, 1'h0);
    wm(3'h0, 1100);
    $display("t_debug done");
  endtask : t_debug

  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  initial
  begin
    #400000;
    miscompares++;
    conclude();
  end

  initial
  begin
    t_init();
    t_normal();
    t_supply();
    t_wdog();
    t_flash();
    t_sleep_off();
    t_sleep_on(1'h1);
    t_sleep_on(1'h0);
    t_debug();
    conclude();
  end
endmodule : sbc_mode_fsm_bench
